// ==== hw/timer3_regs.vh ====
// Register offsets, field positions and reset values for the timer 3 block.
// Assumes an APB slave with 32-bit data, one aligned word per register.
//
// What this block does
// RQ1: Overflow flag bit 7 set on overflow; software clears or sets it.
// RQ2: Capture/compare flag bit 6 set on capture or compare match; software clears/sets.
// RQ3: Bit 5 low counts internal clock; high counts falling edges of counter pin.
// RQ4: Bit 4 set with bit 5 low drives counter pin and toggles it on every overflow.
// RQ5: Bit 3 clears count on capture or compare match in those modes.
// RQ6: Run bit 2 starts or stops the timer; stopped count is kept unless a capture event auto-resets it.
// RQ7: Mode bits: 00 timer, 01 capture, 10 auto-reload, 11 compare.
// RQ8: Capture event copies the count bytes into the capture register.
// RQ9: 16-bit up-counter wraps to zero; auto-reload reloads from capture register.
`ifndef TIMER3_REGS_VH
`define TIMER3_REGS_VH

// ****************************************
// Register byte addresses
// ****************************************
// Control keeps its unaligned register index; its word sits at four times it
`define INDEX_CONTROL 8'hc2
`define ADDR_CONTROL 10'h308
`define ADDR_COUNT_LOW 10'h0c4
`define ADDR_COUNT_HIGH 10'h0c8
`define ADDR_CAPTURE_LOW 10'h0cc
`define ADDR_CAPTURE_HIGH 10'h0d0
`define ADDR_IRQ_STATUS 10'h0d4
`define ADDR_IRQ_MASK 10'h0d8
`define ADDR_WIDTH 10

// ****************************************
// Control fields and reset values
// ****************************************
`define BIT_OVF_FLAG 7
`define BIT_CC_FLAG 6
`define BIT_SOURCE 5
`define BIT_TOGGLE_EN 4
`define BIT_AUTO_RESET 3
`define BIT_RUN 2
`define MODE_TIMER 2'h0
`define MODE_CAPTURE 2'h1
`define MODE_RELOAD 2'h2
`define MODE_COMPARE 2'h3
`define CONTROL_RESET 8'h00
`define IRQ_BIT_OVF 0
`define IRQ_BIT_CC 1

`endif

// ==== hw/edge_sense.v ====
// Falling-edge detector for the synchronous counter pin and capture input.
// Assumes inputs already synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module edge_sense (
  // Clock and reset
  input wire i_clock,
  input wire i_rst_b,
  input wire i_enable,
  // Sampled level
  input wire i_level,
  output wire o_fall
);
  reg last;
  // Reset high so a low pin at start reads as an edge
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      last <= 1'b1;
    end else if (i_enable) begin
      last <= i_level;
    end
  end
  assign o_fall = last & ~i_level;
endmodule // edge_sense
`default_nettype wire

// ==== hw/timer3_capture_compare.v ====
// Timer 3 with capture, auto-reload and compare, APB register slave.
// Assumes synchronous pins, one clock, APB master per the protocol.
`timescale 1ns/1ps
`default_nettype none
`include "timer3_regs.vh"
module timer3_capture_compare #(
  parameter WIDTH = 16
) (
  // Clock, enable and reset
  input wire i_clock,
  input wire i_rst_b,
  input wire i_clken,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [9:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  // Counter pin and capture event
  input wire i_counter_pin,
  input wire i_capture_event,
  output reg o_counter_pin,
  output reg o_counter_pin_oe,
  // Interrupt
  output reg o_irq
);

  // ****************************************
  // State
  // ****************************************
  reg overflow_flag;
  reg capture_compare_flag;
  reg count_source_select;
  reg overflow_toggle_enable;
  reg event_auto_reset;
  reg timer_run;
  reg [1:0] timer_mode_select;
  reg [WIDTH-1:0] count;
  reg [WIDTH-1:0] capture;
  reg [1:0] irq_status;
  reg [1:0] irq_mask;
  wire pin_fall;
  wire cap_fall;

  edge_sense u_pin_edge (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_enable(i_clken),
    .i_level(i_counter_pin),
    .o_fall(pin_fall)
  );

  edge_sense u_cap_edge (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_enable(i_clken),
    .i_level(i_capture_event),
    .o_fall(cap_fall)
  );

  // ****************************************
  // Bus decode
  // ****************************************
  // Writes land in the access cycle; reads are sampled in the setup cycle, zero waits
  wire access = i_psel & i_penable & i_clken;
  wire wr = access & i_pwrite;
  wire wr_ctl = wr && (i_paddr == `ADDR_CONTROL);
  wire wr_cl = wr && (i_paddr == `ADDR_COUNT_LOW);
  wire wr_ch = wr && (i_paddr == `ADDR_COUNT_HIGH);
  wire wr_pl = wr && (i_paddr == `ADDR_CAPTURE_LOW);
  wire wr_ph = wr && (i_paddr == `ADDR_CAPTURE_HIGH);
  wire wr_st = wr && (i_paddr == `ADDR_IRQ_STATUS);
  wire wr_mk = wr && (i_paddr == `ADDR_IRQ_MASK);

  function mapped;
    input [9:0] a;
    begin
      mapped = (a == `ADDR_CONTROL) || (a == `ADDR_COUNT_LOW) ||
        (a == `ADDR_COUNT_HIGH) || (a == `ADDR_CAPTURE_LOW) ||
        (a == `ADDR_CAPTURE_HIGH) || (a == `ADDR_IRQ_STATUS) ||
        (a == `ADDR_IRQ_MASK);
    end
  endfunction

  // ****************************************
  // Counting
  // ****************************************
  wire mode_cap = (timer_mode_select == `MODE_CAPTURE); // RQ7
  wire mode_rel = (timer_mode_select == `MODE_RELOAD); // RQ7
  wire mode_cmp = (timer_mode_select == `MODE_COMPARE); // RQ7
  wire tick = timer_run & (count_source_select ? pin_fall : 1'b1); // RQ3 RQ6
  wire ovf = tick & (&count); // RQ9
  wire cap_ev = mode_cap & cap_fall; // RQ8
  wire cmp_ev = mode_cmp & timer_run & (count == capture); // RQ2
  wire cc_ev = cap_ev | cmp_ev;
  reg [WIDTH-1:0] next_count;

  always @* begin
    next_count = count;
    if (tick) begin
      if (ovf && mode_rel) begin
        next_count = capture; // RQ9
      end else begin
        next_count = count + {{(WIDTH-1){1'b0}}, 1'b1}; // RQ9
      end
    end
    // Event reset wins over a tick in the same cycle
    if (cc_ev && event_auto_reset) begin
      next_count = {WIDTH{1'b0}}; // RQ5
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      overflow_flag <= 1'b0;
      capture_compare_flag <= 1'b0;
      count_source_select <= 1'b0;
      overflow_toggle_enable <= 1'b0;
      event_auto_reset <= 1'b0;
      timer_run <= 1'b0;
      timer_mode_select <= 2'h0;
      count <= {WIDTH{1'b0}};
      capture <= {WIDTH{1'b0}};
      irq_status <= 2'h0;
      irq_mask <= 2'h0;
      o_counter_pin <= 1'b0;
      o_counter_pin_oe <= 1'b0;
      o_irq <= 1'b0;
      o_prdata <= 32'h00000000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else if (i_clken) begin
      if (wr_ctl) begin
        count_source_select <= i_pwdata[`BIT_SOURCE];
        overflow_toggle_enable <= i_pwdata[`BIT_TOGGLE_EN];
        event_auto_reset <= i_pwdata[`BIT_AUTO_RESET];
        timer_run <= i_pwdata[`BIT_RUN];
        timer_mode_select <= i_pwdata[1:0];
      end
      // Software may clear or set; a hardware event wins
      if (ovf) begin
        overflow_flag <= 1'b1; // RQ1
      end else if (wr_ctl) begin
        overflow_flag <= i_pwdata[`BIT_OVF_FLAG]; // RQ1
      end
      if (cc_ev) begin
        capture_compare_flag <= 1'b1; // RQ2
      end else if (wr_ctl) begin
        capture_compare_flag <= i_pwdata[`BIT_CC_FLAG]; // RQ2
      end
      // Count writes override counting; stopped count holds unless a capture event auto-resets it
      count <= next_count; // RQ6
      if (wr_cl) begin
        count[7:0] <= i_pwdata[7:0];
      end
      if (wr_ch) begin
        count[WIDTH-1:8] <= i_pwdata[WIDTH-9:0];
      end
      if (cap_ev) begin
        capture <= count; // RQ8
      end else begin
        if (wr_pl) begin
          capture[7:0] <= i_pwdata[7:0];
        end
        if (wr_ph) begin
          capture[WIDTH-1:8] <= i_pwdata[WIDTH-9:0];
        end
      end
      // Pin drive stays on while toggling is enabled and bit 5 selects the internal clock
      o_counter_pin_oe <= overflow_toggle_enable & ~count_source_select;
      if (ovf && overflow_toggle_enable) begin
        o_counter_pin <= ~o_counter_pin; // RQ4
      end
      irq_status[`IRQ_BIT_OVF] <= ovf |
        (irq_status[`IRQ_BIT_OVF] & ~(wr_st & i_pwdata[`IRQ_BIT_OVF]));
      irq_status[`IRQ_BIT_CC] <= cc_ev |
        (irq_status[`IRQ_BIT_CC] & ~(wr_st & i_pwdata[`IRQ_BIT_CC]));
      if (wr_mk) begin
        irq_mask <= i_pwdata[1:0];
      end
      o_irq <= |(irq_status & irq_mask);
      // Ready in the access cycle's first edge, low otherwise
      o_pready <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~mapped(i_paddr);
      if (i_psel && !i_penable && !i_pwrite) begin
        case (i_paddr)
          `ADDR_CONTROL: o_prdata <= {24'h000000, overflow_flag, capture_compare_flag,
            count_source_select, overflow_toggle_enable, event_auto_reset,
            timer_run, timer_mode_select};
          `ADDR_COUNT_LOW: o_prdata <= {24'h000000, count[7:0]};
          `ADDR_COUNT_HIGH: o_prdata <= {24'h000000, count[WIDTH-1:8]};
          `ADDR_CAPTURE_LOW: o_prdata <= {24'h000000, capture[7:0]};
          `ADDR_CAPTURE_HIGH: o_prdata <= {24'h000000, capture[WIDTH-1:8]};
          `ADDR_IRQ_STATUS: o_prdata <= {30'h00000000, irq_status};
          `ADDR_IRQ_MASK: o_prdata <= {30'h00000000, irq_mask};
          default: o_prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // timer3_capture_compare
`default_nettype wire

// ==== test/timer3_pin_model.sv ====
// Model of the external event source: counter pin and capture input.
// Assumes the bench asks for pulses right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module timer3_pin_model (
  input wire logic i_clock,
  input wire logic i_pulse,
  input wire logic i_capture,
  output logic o_pin,
  output logic o_cap
);
  initial begin
    o_pin = 1'b1;
    o_cap = 1'b1;
  end
  // Idle high like a pulled-up pin; one falling edge per two pulse cycles
  always @(posedge i_clock) begin
    o_pin <= i_pulse ? ~o_pin : 1'b1;
    o_cap <= ~i_capture;
  end
endmodule // timer3_pin_model
`default_nettype wire

// ==== test/timer3_capture_compare_chk.sv ====
// Port-level checker for the timer 3 block.
// Assumes i_clken high whenever register writes are shadowed here.
`timescale 1ns/1ps
`default_nettype none
module timer3_capture_compare_chk (
  input wire logic i_clock, i_rst_b, i_clken, i_psel, i_penable, i_pwrite,
  input wire logic [9:0] i_paddr,
  input wire logic [31:0] i_pwdata, o_prdata,
  input wire logic o_pready, o_pslverr, o_counter_pin, o_counter_pin_oe, o_irq
);
  // ***
  // Shadow of the software-only control bits
  // ***
  logic [5:0] ctl, ctl_q;
  wire wr = i_psel & i_penable & o_pready & i_pwrite;
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctl <= 6'h00;
      ctl_q <= 6'h00;
    end else begin
      ctl_q <= ctl;
      if (wr && i_paddr == 10'h308) ctl <= i_pwdata[5:0];
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  sequence s_setup; i_psel && !i_penable && i_clken; endsequence
  sequence s_access; i_psel && i_penable && o_pready; endsequence
  property p_ready; s_setup |=> o_pready; endproperty
  a_ready: assert property (p_ready) else $error("pready late");
  property p_pulse; o_pready |=> !o_pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready too long");
  property p_err; o_pslverr |-> o_pready; endproperty
  a_err: assert property (p_err) else $error("pslverr alone");
  property p_rd0; s_access ##0 (o_pslverr && !i_pwrite) |-> o_prdata == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("unmapped read not zero");
  property p_map;
    s_setup ##0 (i_paddr inside {10'h308, 10'h0c4, 10'h0c8, 10'h0cc, 10'h0d0, 10'h0d4,
      10'h0d8}) |=> !o_pslverr;
  endproperty
  a_map: assert property (p_map) else $error("mapped address refused");
  property p_oe; ctl == ctl_q |-> o_counter_pin_oe == (ctl[4] & !ctl[5]); endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_tog; $changed(o_counter_pin) |-> $past(ctl[4]); endproperty
  a_tog: assert property (p_tog) else $error("pin toggled while disabled");
  property p_irq; wr && i_paddr == 8'hd8 && i_pwdata[1:0] == 2'h0 |=> ##1 !o_irq; endproperty
  a_irq: assert property (p_irq) else $error("masked interrupt high");
endmodule // timer3_capture_compare_chk
`default_nettype wire

// ==== test/timer3_capture_compare_bench.sv ====
// Self-checking bench for the timer 3 block over APB.
// Assumes one wait-free APB access and the pin model on the event inputs.
`timescale 1ns/1ps
`default_nettype none
module timer3_capture_compare_bench;
  logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, req = 0, cap = 0, err;
  logic [9:0] paddr = 10'h000;
  // Control word address: register index 0xc2 times four
  localparam logic [9:0] CTL = 10'h308;
  logic [31:0] pwdata = 32'h0, q, d;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, pin_o, oe, irq, pin, capev;
  int err_total = 0, cmp_count = 0, cyc = 0;
  `define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_total++; \
    $display("ERROR %s exp %h got %h", n, e, s); end end
  always #12.5 clk = ~clk;
  timer3_capture_compare uut (.i_clock(clk), .i_rst_b(rst_b), .i_clken(1'b1), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_counter_pin(pin), .i_capture_event(capev),
    .o_counter_pin(pin_o), .o_counter_pin_oe(oe), .o_irq(irq));
  timer3_pin_model pm (.i_clock(clk), .i_pulse(req), .i_capture(cap), .o_pin(pin),
    .o_cap(capev));
  // ***
  // Bus tasks
  // ***
  task apb(input logic w, input logic [9:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk) {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, a, v};
    @(posedge clk) pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && n++ < 20);
    if (pready !== 1'b1) begin
      err_total++;
      $display("ERROR pready exp 1 got %b", pready);
    end
    q = prdata;
    err = pslverr;
    {psel, pen} <= 2'h0;
  endtask
  task wr(input logic [9:0] a, input logic [31:0] v); apb(1'b1, a, v); endtask
  task rd(input logic [9:0] a); apb(1'b0, a, 32'h0); endtask
  task settle; repeat (2) @(negedge clk); endtask
  // ***
  // Scenarios
  // ***
  task t_regs;
    rd(CTL); `CHK("control", 32'h0, q)
    rd(8'hd8); `CHK("mask", 32'h0, q)
    wr(8'he0, 32'h5a); `CHK("unmapped err", 1'b1, err)
    rd(8'he0); `CHK("unmapped data", 32'h0, q)
  endtask
  task t_timer;
    wr(8'hc4, 32'hff); wr(8'hc8, 32'hff); wr(8'hd8, 32'h1); wr(CTL, 32'h14);
    repeat (4) @(posedge clk);
    rd(CTL); `CHK("ovf flag", 32'h94, q)
    settle; `CHK("pin", 1'b1, pin_o)
    `CHK("oe", 1'b1, oe)
    `CHK("irq", 1'b1, irq)
    wr(CTL, 32'h10); rd(CTL); `CHK("flag clear", 32'h10, q)
    rd(8'hc8); `CHK("wrap", 32'h0, q)
    rd(8'hc4); d = q; repeat (5) @(posedge clk);
    rd(8'hc4); `CHK("hold", d, q)
    wr(8'hd8, 32'h0); settle; `CHK("masked", 1'b0, irq)
    wr(8'hd4, 32'h1); wr(8'hd8, 32'h1); settle; `CHK("cleared", 1'b0, irq)
    rd(8'hd4); `CHK("status", 32'h0, q)
  endtask
  task t_ext;
    wr(8'hc4, 32'h0); wr(8'hc8, 32'h0); wr(CTL, 32'h24);
    @(posedge clk) req <= 1'b1;
    repeat (10) @(posedge clk);
    req <= 1'b0;
    repeat (4) @(posedge clk);
    wr(CTL, 32'h20); rd(8'hc4); `CHK("edges", 32'h5, q)
  endtask
  task t_cap;
    wr(8'hc4, 32'hf0); wr(8'hc8, 32'h12); wr(CTL, 32'h0d);
    @(posedge clk) cap <= 1'b1;
    @(posedge clk) cap <= 1'b0;
    repeat (4) @(posedge clk);
    rd(CTL); `CHK("cap flag", 32'h4d, q)
    wr(CTL, 32'h09); rd(8'hd0); `CHK("captured", 32'h12, q)
    rd(8'hc8); `CHK("auto reset", 32'h0, q)
  endtask
  task t_cmp;
    wr(8'hcc, 32'h10); wr(8'hd0, 32'h0); wr(8'hc4, 32'h0); wr(8'hc8, 32'h0); wr(CTL, 32'h0f);
    repeat (40) @(posedge clk);
    rd(CTL); `CHK("cmp flag", 32'h4f, q)
    rd(8'hc4); `CHK("cmp reset", 1'b1, q <= 32'h10)
    wr(CTL, 32'h03); wr(8'hd0, 32'hff); wr(8'hc4, 32'hfe); wr(8'hc8, 32'hff); wr(CTL, 32'h06);
    repeat (6) @(posedge clk);
    rd(8'hc8); `CHK("reload", 32'hff, q)
  endtask
  task finish_test;
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_regs; t_timer; t_ext; t_cap; t_cmp;
    finish_test;
  end
  // Bounded run: a hang counts as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      finish_test;
    end
  end
endmodule // timer3_capture_compare_bench
bind timer3_capture_compare timer3_capture_compare_chk chk (.*);
`default_nettype wire
